// File: ivmap_pkg.sv
// ivmap_pkg: constants and types shared by the interrupt vector map
// =============================================
// Overview of operation
// - spacing one word in small variants, two in large; address is base plus index times spacing
// - smallest variant has no boot section; vectors never relocate
// - with boot section, boot-reset fuse selects the address fetched after reset
// - with boot section, vector-select bit in MCU control register picks vector base
// - every reset cause takes vector 1 at the reset address, 0x000 unless the boot-reset fuse is programmed in a variant with boot section
// - external request 0 at 0x001, external request 1 at 0x002
// - pin-change groups 0,1,2 at 0x003, 0x004, 0x005
// - watchdog 0x006; timer 2 compare A 0x007, B 0x008, overflow 0x009
// - timer 1 capture 0x00A, compare A 0x00B, B 0x00C, overflow 0x00D
// - timer 0 compare A 0x00E, compare B 0x00F, overflow 0x010
// - SPI 0x011, USART receive 0x012, buffer empty 0x013, transmit 0x014
// - converter 0x015, EEPROM 0x016, comparator 0x017, two-wire 0x018, self-program 0x019
// - with boot section, vector-select set adds boot section start to every interrupt vector address
// - fuse 1 unprogrammed resets at 0x000; fuse 0 programmed resets at boot address with boot section, at 0x000 in the smallest variant
package ivmap_pkg;

  localparam int ADDR_W      = 16;
  localparam int NUM_IRQ     = 25;
  localparam int VEC_W       = 5;

  // =============================================
  // variants
  typedef enum logic [1:0] {
    IVMAP_SMALL,
    IVMAP_MID,
    IVMAP_LARGE_A,
    IVMAP_LARGE_B
  } ivmap_variant_t;

  localparam logic [1:0]        SPACING_ONE  = 2'h1;
  localparam logic [1:0]        SPACING_TWO  = 2'h2;
  localparam logic [ADDR_W-1:0] RESET_ADDR   = 16'h0000;
  localparam logic [VEC_W-1:0]  RESET_VEC_NO = 5'h01;
  // interrupt index i (0..24) is vector number i+2 at table index i+1
  localparam logic [VEC_W-1:0]  FIRST_IRQ_VEC = 5'h02;
  localparam logic              FUSE_UNPROGRAMMED = 1'h1;
  localparam logic              FUSE_PROGRAMMED   = 1'h0;

  // source bit positions in the request vector
  localparam int SRC_EXT0     = 0;
  localparam int SRC_EXT1     = 1;
  localparam int SRC_PCG0     = 2;
  localparam int SRC_PCG1     = 3;
  localparam int SRC_PCG2     = 4;
  localparam int SRC_WDOG     = 5;
  localparam int SRC_T2_CMPA  = 6;
  localparam int SRC_T2_CMPB  = 7;
  localparam int SRC_T2_OVF   = 8;
  localparam int SRC_T1_CAPT  = 9;
  localparam int SRC_T1_CMPA  = 10;
  localparam int SRC_T1_CMPB  = 11;
  localparam int SRC_T1_OVF   = 12;
  localparam int SRC_T0_CMPA  = 13;
  localparam int SRC_T0_CMPB  = 14;
  localparam int SRC_T0_OVF   = 15;
  localparam int SRC_SPI_DONE = 16;
  localparam int SRC_RX_DONE  = 17;
  localparam int SRC_TX_EMPTY = 18;
  localparam int SRC_TX_DONE  = 19;
  localparam int SRC_CONV     = 20;
  localparam int SRC_EEPROM   = 21;
  localparam int SRC_COMP     = 22;
  localparam int SRC_TWOWIRE  = 23;
  localparam int SRC_SELFPROG = 24;

  // table word index of each source (before spacing)
  function automatic logic [ADDR_W-1:0] ivmap_table_index(input logic [VEC_W-1:0] src);
    ivmap_table_index = {11'h000, src} + 16'h0001;
  endfunction

  function automatic logic [1:0] ivmap_spacing(input ivmap_variant_t v);
    ivmap_spacing = (v == IVMAP_LARGE_A || v == IVMAP_LARGE_B) ? SPACING_TWO : SPACING_ONE;
  endfunction

endpackage

// File: ivmap_prio.sv
// ivmap_prio: fixed priority picker, lowest source index wins
`timescale 1ns/1ns
`default_nettype none
module ivmap_prio
  import ivmap_pkg::*;
(
  input  wire logic [NUM_IRQ-1:0] req,
  output logic                    any,
  output logic [VEC_W-1:0]        idx
);

  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = VEC_W'(i);
      end
    end
  end

endmodule
`default_nettype wire

// File: ivmap_top.sv
// ivmap_top: reset and interrupt vector address generator for the core
`timescale 1ns/1ns
`default_nettype none
module ivmap_top
  import ivmap_pkg::*;
#(
  parameter ivmap_variant_t    VARIANT         = IVMAP_MID,
  parameter logic [ADDR_W-1:0] BOOT_START_ADDR = 16'h0C00
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               bootResetFuse,
  input  wire logic               vectorSelectBit,
  input  wire logic               globalEnable,
  input  wire logic [NUM_IRQ-1:0] irqPending,
  input  wire logic [NUM_IRQ-1:0] irqEnable,
  input  wire logic               irqAck,
  output logic                    irqRequest,
  output logic [VEC_W-1:0]        irqVectorNo,
  output logic [ADDR_W-1:0]       irqVectorAddr,
  output logic [ADDR_W-1:0]       resetAddr,
  output logic                    ackPulse,
  output logic [VEC_W-1:0]        ackSource
);

  // =============================================
  // variant decode
  localparam logic HAS_BOOT = (VARIANT != IVMAP_SMALL);

  logic             fuseLatched_reg;
  logic             fuseCaught_reg;
  logic             anyReq;
  logic [VEC_W-1:0] winIdx;
  logic [ADDR_W-1:0] vecAddr_next;
  logic [ADDR_W-1:0] ivBase;

  // =============================================
  // fuse capture: fuse is a level strap, caught after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      fuseCaught_reg  <= 1'b0;
      fuseLatched_reg <= FUSE_UNPROGRAMMED;
    end else if (!fuseCaught_reg) begin
      fuseCaught_reg  <= 1'b1;
      fuseLatched_reg <= bootResetFuse;
    end
  end

  // =============================================
  // reset fetch address; every reset cause lands here
  always_ff @(posedge clk) begin
    if (rst) begin
      resetAddr <= RESET_ADDR;
    end else if (HAS_BOOT && fuseCaught_reg && fuseLatched_reg == FUSE_PROGRAMMED) begin
      resetAddr <= BOOT_START_ADDR;
    end else begin
      resetAddr <= RESET_ADDR;
    end
  end

  // =============================================
  // arbitration among enabled pending sources
  ivmap_prio u_prio (
    .req (irqPending & irqEnable & {NUM_IRQ{globalEnable}}),
    .any (anyReq),
    .idx (winIdx)
  );

  // small variant ignores the vector-select bit entirely
  always_comb begin
    if (HAS_BOOT && vectorSelectBit) begin
      ivBase = BOOT_START_ADDR;
    end else begin
      ivBase = RESET_ADDR;
    end
  end

  // table order fixes each source address: ext 0x001.. self-program 0x019
  always_comb begin
    vecAddr_next = ivBase
                 + ADDR_W'(ivmap_table_index(winIdx) * {14'h0000, ivmap_spacing(VARIANT)});
  end

  // =============================================
  // request presentation, held stable until acknowledged
  logic holding_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      holding_reg   <= 1'b0;
      irqRequest    <= 1'b0;
      irqVectorNo   <= '0;
      irqVectorAddr <= RESET_ADDR;
    end else if (holding_reg && irqAck) begin
      holding_reg <= 1'b0;
      irqRequest  <= 1'b0;
    end else if (!holding_reg) begin
      // re-evaluated each idle cycle; the first winner is then held even if a lower vector arrives
      holding_reg   <= anyReq;
      irqRequest    <= anyReq;
      irqVectorNo   <= anyReq ? winIdx + FIRST_IRQ_VEC : '0;
      irqVectorAddr <= anyReq ? vecAddr_next : RESET_ADDR;
    end
  end

  // =============================================
  // acknowledge report so the source can clear its flag
  always_ff @(posedge clk) begin
    if (rst) begin
      ackPulse  <= 1'b0;
      ackSource <= '0;
    end else begin
      ackPulse  <= holding_reg && irqAck;
      ackSource <= irqVectorNo - FIRST_IRQ_VEC;
    end
  end

endmodule
`default_nettype wire

// File: ivmap_monitor.sv
// ivmap_monitor: concurrent checks on the vector map ports
`timescale 1ns/1ns
`default_nettype none
module ivmap_monitor
  import ivmap_pkg::*;
#(
  parameter ivmap_variant_t    VARIANT         = IVMAP_MID,
  parameter logic [ADDR_W-1:0] BOOT_START_ADDR = 16'h0C00
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               bootResetFuse,
  input wire logic               vectorSelectBit,
  input wire logic               globalEnable,
  input wire logic [NUM_IRQ-1:0] irqPending,
  input wire logic [NUM_IRQ-1:0] irqEnable,
  input wire logic               irqAck,
  input wire logic               irqRequest,
  input wire logic [VEC_W-1:0]   irqVectorNo,
  input wire logic [ADDR_W-1:0]  irqVectorAddr,
  input wire logic [ADDR_W-1:0]  resetAddr,
  input wire logic               ackPulse,
  input wire logic [VEC_W-1:0]   ackSource
);
  localparam logic [15:0] SP = (VARIANT >= IVMAP_LARGE_A) ? 16'h2 : 16'h1;
  localparam logic [15:0] BASE = (VARIANT == IVMAP_SMALL) ? 16'h0 : BOOT_START_ADDR;
  logic [NUM_IRQ-1:0] live;
  assign live = irqPending & irqEnable;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_GRANT: assert property (!irqRequest && globalEnable && |live |=> irqRequest)
    else $error("pending request not granted");
  AST_IDLE: assert property (!irqRequest && !(globalEnable && |live) |=> !irqRequest)
    else $error("grant without request");
  AST_HOLD: assert property (irqRequest && !irqAck |=> irqRequest && $stable(irqVectorAddr))
    else $error("vector not held");
  AST_DROP: assert property (irqRequest && irqAck |=> !irqRequest && ackPulse
    && ackSource == $past(irqVectorNo) - 5'h02) else $error("bad ack");
  AST_PULSE: assert property (ackPulse |-> $past(irqRequest && irqAck))
    else $error("stray ack pulse");
  AST_LOWEST: assert property ($rose(irqRequest) |-> ($past(live) & ((25'h2 << (irqVectorNo -
    5'h02)) - 25'h1)) == (25'h1 << (irqVectorNo - 5'h02))) else $error("wrong winner");
  AST_ADDR: assert property ($rose(irqRequest) |-> irqVectorAddr ==
    ($past(vectorSelectBit) ? BASE : 16'h0) + SP * {11'h0, irqVectorNo - 5'h01})
    else $error("bad vector address");
  AST_RADDR: assert property (!$past(rst) && !$past(rst, 2) |-> resetAddr ==
    ((VARIANT == IVMAP_SMALL || $past(bootResetFuse)) ? 16'h0 : BOOT_START_ADDR))
    else $error("bad reset address");
  cover property (irqRequest && irqAck);
  cover property (irqRequest && !irqAck ##1 irqRequest && !irqAck);
  cover property ($rose(irqRequest) && vectorSelectBit);
endmodule
bind ivmap_top ivmap_monitor #(.VARIANT(VARIANT), .BOOT_START_ADDR(BOOT_START_ADDR)) mon (
  .clk(clk), .rst(rst), .bootResetFuse(bootResetFuse), .vectorSelectBit(vectorSelectBit),
  .globalEnable(globalEnable), .irqPending(irqPending), .irqEnable(irqEnable),
  .irqAck(irqAck), .irqRequest(irqRequest), .irqVectorNo(irqVectorNo),
  .irqVectorAddr(irqVectorAddr), .resetAddr(resetAddr), .ackPulse(ackPulse),
  .ackSource(ackSource));
`default_nettype wire

// File: ivmap_core_model.sv
// ivmap_core_model: core side taking presented vectors, fast or slow
`timescale 1ns/1ns
`default_nettype none
module ivmap_core_model (
  input wire logic  clk,
  input wire logic  rst,
  input wire logic  irqRequest,
  input wire logic  slowAck,
  output logic      irqAck
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk) begin
    if (rst || !irqRequest || irqAck) wait_reg <= 2'h0;
    else wait_reg <= wait_reg + 2'h1;
  end
  // slow mode lets the vector stand three extra cycles
  assign irqAck = irqRequest && (!slowAck || wait_reg == 2'h3);
endmodule
`default_nettype wire

// File: interrupt_vector_map_tb.sv
// interrupt_vector_map_tb: random and corner tests of the vector map
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_map_tb;
  import ivmap_pkg::*;
  localparam logic [15:0] BOOT = 16'h0C00;
  logic clk = 1'b0, rst = 1'b1, fuse = 1'b1, vsel = 1'b0, gEn = 1'b1, slow = 1'b0;
  logic [24:0] pend = '0, en = '0, p, q;
  logic irqRequest, irqAck, ackPulse;
  logic [4:0] vno, ackSource;
  logic [15:0] vaddr, raddr, vaddrS, raddrS;
  int mismatches = 0, n_tests = 0, seed = 32'h315b, i;
  always #5 clk = ~clk;
  ivmap_top #(.VARIANT(IVMAP_LARGE_B), .BOOT_START_ADDR(BOOT)) uut (.clk(clk), .rst(rst),
    .bootResetFuse(fuse), .vectorSelectBit(vsel), .globalEnable(gEn), .irqPending(pend),
    .irqEnable(en), .irqAck(irqAck), .irqRequest(irqRequest), .irqVectorNo(vno),
    .irqVectorAddr(vaddr), .resetAddr(raddr), .ackPulse(ackPulse), .ackSource(ackSource));
  // smallest variant in lockstep: one-word spacing, never relocated
  ivmap_top #(.VARIANT(IVMAP_SMALL), .BOOT_START_ADDR(BOOT)) uutSmall (.clk(clk), .rst(rst),
    .bootResetFuse(fuse), .vectorSelectBit(vsel), .globalEnable(gEn), .irqPending(pend),
    .irqEnable(en), .irqAck(irqAck), .irqRequest(), .irqVectorNo(),
    .irqVectorAddr(vaddrS), .resetAddr(raddrS), .ackPulse(), .ackSource());
  ivmap_core_model core (.clk(clk), .rst(rst), .irqRequest(irqRequest), .slowAck(slow),
    .irqAck(irqAck));
  // ==========================================
  // checking helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic int lowest(input logic [24:0] v);
    lowest = 24;
    for (int b = 24; b >= 0; b--) if (v[b]) lowest = b;
  endfunction
  // pending cleared once acked so no regrant follows
  task automatic serve(input logic [24:0] pv, input logic [24:0] ev, input logic vs, input int s);
    int k;
    @(negedge clk);
    pend = pv;
    en = ev;
    vsel = vs;
    for (k = 0; k < 20 && irqRequest !== 1'b1; k++) @(negedge clk);
    check(16'(irqRequest), 16'h1);
    check(vaddr, (vs ? BOOT : 16'h0) + 16'(s + 1) * 16'h2);
    check(vaddrS, 16'(s + 1));
    check(16'(vno), 16'(s + 2));
    for (k = 0; k < 20 && ackPulse !== 1'b1; k++) @(negedge clk);
    pend = '0;
    check(16'(ackPulse), 16'h1);
    check(16'(ackSource), 16'(s));
  endtask
  initial begin
    for (i = 0; i < 2; i++) begin
      rst = 1'b1;
      fuse = i[0];
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      check(raddr, fuse ? 16'h0 : BOOT);
      check(raddrS, 16'h0);
    end
    for (i = 0; i < NUM_IRQ; i++) serve(25'h1 << i, '1, i[0], i);
    @(negedge clk);
    gEn = 1'b0;
    pend = '1;
    repeat (4) @(negedge clk);
    check(16'(irqRequest), 16'h0);
    pend = '0;
    gEn = 1'b1;
    repeat (40) begin
      p = 25'($random(seed)) | 25'h1000000;
      // winner must come from the mask this serve applies, not the previous one
      q = 25'($random(seed)) | 25'h1000000;
      slow = 1'($random(seed));
      serve(p, q, 1'($random(seed)), lowest(p & q));
    end
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
